// ### timing_pkg.sv
// Package: constants and enumerations for the instruction cycle timing model
package timing_pkg;

  // ****************************************
  // Instruction classes
  // ****************************************
  typedef enum logic [3:0] {
    CLS_BRANCH    = 4'h0,
    CLS_MONITOR   = 4'h1,
    CLS_STORE_VI  = 4'h2,
    CLS_RESTORE_VI = 4'h3,
    CLS_MOVE_WM   = 4'h4,
    CLS_LOAD_AM   = 4'h5,
    CLS_DEC_ADD   = 4'h6,
    CLS_TABLE_LU  = 4'h7,
    CLS_DIV_ZERO  = 4'h8,
    CLS_EDIT      = 4'h9,
    CLS_PERIPH    = 4'hA,
    CLS_TERM      = 4'hB,
    CLS_CSM       = 4'hC
  } instr_class_e;

  // ****************************************
  // Timing counts in half memory cycles; group, switch, probability and sector constants
  // ****************************************
  localparam logic [15:0] ONE_CYCLE_H = 16'h0002;
  localparam logic [15:0] INTR_CYCLES_H = 16'h0006;
  localparam logic [15:0] TERM_B_CYCLES_H = 16'h0004;
  localparam logic [15:0] ODD_EXTRA_H = 16'h0002;
  localparam int GROUP_CHARS = 4;
  localparam int SENSE_SWITCHES = 8;
  // Remainder correction probability per quotient step, in millionths
  localparam int CORR_PROB_PPM = 5560;
  localparam int SECTOR_W = 2;

  // ****************************************
  // Sequencer states (Gray coded)
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_IO   = 2'b11,
    ST_INTR = 2'b10
  } seq_state_e;

endpackage

// ### cycle_counter.sv
// Counter of half memory cycles with terminal detection
`timescale 1ns/1ps
`default_nettype none
module cycle_counter #(
  parameter int W = 16
) (
  input wire logic mclk, // Processor clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic load, // Load new count
  input wire logic [W-1:0] load_val, // Count to load
  input wire logic dec, // Decrement by one half cycle
  output logic zero // Count is zero
);
  logic [W-1:0] cnt_r;

  // ****************************************
  // Counter
  // ****************************************
  assign zero = (cnt_r == '0);

  // Load wins over decrement
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_r <= load_val;
      end else if (dec && !zero) begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ### instr_timing.sv
// Top module: per-instruction memory-cycle accounting
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Item-marked opcode under trapping runs as sequencing-mode change, one cycle.
// - Each serviced interrupt or monitor-call signal costs three extra cycles; only ext_intr pin interrupts are counted here.
// - Interrupt during transfer with busy channel restarts instruction extraction.
// - After channel character, characters move only in the sector's slot.
// - Branches take one cycle, including all eight sense switch tests.
// - Monitor call takes one cycle; its interrupt is not counted in this block.
// - Store variant: half cycle per character stored or skipped, plus one.
// - Restore variant: half cycle per character referenced, plus one.
// - Moves add one cycle when terminating field length is odd.
// - Decimal add on sign change adds twice the B groups, rounded up.
// - Termination term adds zero in A-field, two when only B-field.
// - Table lookup costs per-scan time times number of scans.
// - Divide by zero takes one plus two per divisor digit pair.
// - Divide estimates use remainder correction probability 0.00556 per step.
// - Edit dollar count is zero when floating dollar sign unused.
module instr_timing
  import timing_pkg::*;
#(
  parameter int LEN_W = 12,
  parameter int CNT_W = 16
) (
  input wire logic mclk, // Processor clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic start, // Pulse: begin an instruction
  output logic start_ready, // Ready for a new instruction
  input wire timing_pkg::instr_class_e iclass, // Instruction class
  input wire logic item_mark, // Opcode carries an item mark
  input wire logic im_trap, // Item-mark trapping active
  input wire logic [LEN_W-1:0] len_a, // A-operand length or char count
  input wire logic [LEN_W-1:0] len_b, // B-operand length or dollar/quotient-step count
  input wire logic sign_change, // Result sign differs from original
  input wire logic term_in_a, // Terminating punctuation in A-field
  input wire logic float_dollar, // Floating dollar sign used
  input wire logic [7:0] sense_sw, // Sense switch pins
  input wire logic [LEN_W-1:0] base_cyc, // Cycles until channel char is extracted
  input wire logic [timing_pkg::SECTOR_W-1:0] sector, // Sector bits of control character
  input wire logic [LEN_W-1:0] io_chars, // Characters after the control character
  input wire logic [timing_pkg::SECTOR_W-1:0] slot_sector, // Sector owning current cycle
  input wire logic rwc_busy, // Addressed read/write channel busy
  input wire logic ext_intr, // External interrupt pin
  output logic io_strobe, // Character handed to sector traffic control
  output logic [timing_pkg::SECTOR_W-1:0] io_sector, // Sector of the strobed character
  output logic [7:0] sense_val, // Sense switches tested by branch
  output logic restart, // Pulse: transfer extraction restarts
  output logic done, // Pulse: instruction complete
  output logic [CNT_W-1:0] cycles_half, // Counted time in half cycles
  output logic [31:0] corr_est_ppm // Divide correction estimate, millionths
);
  // ****************************************
  // Declarations
  // ****************************************
  seq_state_e state_r, state_nxt;
  logic [CNT_W-1:0] total_r, load_val;
  logic [LEN_W-1:0] io_left_r;
  logic [2:0] intr_sync_r;
  logic intr_pend_r, intr_edge, cnt_zero, load, csm_trap;
  logic [CNT_W-1:0] half_a, half_b, groups_b, cost_h, tlu_h, edit_h, div_h;
  logic odd_term;
  logic [CNT_W-1:0] io_base_h;
  logic slot_hit;

  // ****************************************
  // Interrupt pin synchroniser and edge
  // ****************************************
  assign intr_edge = intr_sync_r[1] && !intr_sync_r[2];

  always_ff @(posedge mclk) begin
    if (rst) begin
      intr_sync_r <= 3'h0;
    end else if (ce) begin
      intr_sync_r <= {intr_sync_r[1:0], ext_intr};
    end
  end

  // ****************************************
  // Cycle cost decode, in half cycles
  // ****************************************
  assign half_a = CNT_W'(len_a);
  assign half_b = CNT_W'(len_b);
  assign groups_b = CNT_W'((len_b + LEN_W'(GROUP_CHARS - 1)) >> 2);
  assign odd_term = len_a[0];
  assign csm_trap = im_trap && item_mark;
  // Per-scan cost is one half cycle per A and B character
  assign tlu_h = CNT_W'((half_a + half_b) * CNT_W'(base_cyc));
  assign edit_h = (half_a << 1) + (float_dollar ? (half_b << 1) : '0);
  // Pairs of divisor digits, rounded up
  assign div_h = ONE_CYCLE_H + (CNT_W'((len_a + LEN_W'(1)) >> 1) << 2);
  assign io_base_h = CNT_W'(base_cyc) << 1;

  always_comb begin
    cost_h = ONE_CYCLE_H;
    if (csm_trap) begin
      cost_h = ONE_CYCLE_H;
    end else begin
      case (iclass)
        CLS_BRANCH: cost_h = ONE_CYCLE_H;
        CLS_MONITOR: cost_h = ONE_CYCLE_H;
        CLS_STORE_VI: cost_h = half_a + ONE_CYCLE_H;
        CLS_RESTORE_VI: cost_h = half_a + ONE_CYCLE_H;
        CLS_MOVE_WM, CLS_LOAD_AM: cost_h = (half_a << 1) + (odd_term ? ODD_EXTRA_H : '0);
        CLS_DEC_ADD: cost_h = sign_change ? (groups_b << 2) : '0;
        CLS_TABLE_LU: cost_h = tlu_h;
        CLS_DIV_ZERO: cost_h = div_h;
        CLS_EDIT: cost_h = edit_h;
        CLS_PERIPH: cost_h = io_base_h;
        CLS_TERM: cost_h = term_in_a ? '0 : TERM_B_CYCLES_H;
        CLS_CSM: cost_h = ONE_CYCLE_H;
        default: cost_h = ONE_CYCLE_H;
      endcase
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign start_ready = (state_r == ST_IDLE);
  assign slot_hit = (slot_sector == sector);
  assign io_strobe = (state_r == ST_IO) && slot_hit && (io_left_r != '0) && ce;
  assign io_sector = sector;
  assign load = (state_r == ST_IDLE && start) || (state_r == ST_RUN && intr_pend_r && cnt_zero);
  assign load_val = (state_r == ST_IDLE) ? cost_h : INTR_CYCLES_H;
  assign restart = ce && intr_edge && rwc_busy && (state_r == ST_IO);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start) state_nxt = ST_RUN;
      ST_RUN: begin
        if (cnt_zero) begin
          if (intr_pend_r) begin
            state_nxt = ST_INTR;
          end else if (iclass == CLS_PERIPH && !csm_trap) begin
            state_nxt = ST_IO;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_IO: begin
        if (restart) begin
          state_nxt = ST_IDLE;
        end else if (io_left_r == '0) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_INTR: if (cnt_zero) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  cycle_counter #(.W(CNT_W)) u_cnt (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .load(load),
    .load_val(load_val),
    .dec(state_r == ST_RUN || state_r == ST_INTR),
    .zero(cnt_zero)
  );

  // State, accounting and outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      total_r <= '0;
      io_left_r <= '0;
      intr_pend_r <= 1'b0;
      done <= 1'b0;
      cycles_half <= '0;
      sense_val <= 8'h00;
      corr_est_ppm <= 32'h0;
    end else if (ce) begin
      state_r <= state_nxt;
      done <= 1'b0;
      // Interrupt caught while idle or running is serviced at the end; an edge during IO or INTR is dropped
      if (intr_edge && (state_r == ST_RUN || state_r == ST_IDLE)) begin
        intr_pend_r <= 1'b1;
      end else if (state_r == ST_INTR) begin
        intr_pend_r <= 1'b0;
      end
      if (state_r == ST_IDLE && start) begin
        total_r <= cost_h;
        io_left_r <= io_chars;
        if (iclass == CLS_BRANCH) begin
          sense_val <= sense_sw;
        end
        corr_est_ppm <= 32'(len_b) * 32'(CORR_PROB_PPM);
      end
      if (load && state_r == ST_RUN) begin
        total_r <= total_r + INTR_CYCLES_H;
      end
      if (io_strobe) begin
        io_left_r <= io_left_r - LEN_W'(1);
        total_r <= total_r + ONE_CYCLE_H;
      end else if (state_r == ST_IO) begin
        total_r <= total_r + ONE_CYCLE_H;
      end
      if (state_r != ST_IDLE && state_nxt == ST_IDLE && !restart) begin
        done <= 1'b1;
        cycles_half <= total_r;
      end
    end
  end
endmodule
`default_nettype wire

// ### instr_timing_properties.sv
// Concurrent checks on the instruction cycle timing block
`timescale 1ns/1ps
`default_nettype none
module instr_timing_checker
  import timing_pkg::*;
#(
  parameter int LEN_W = 12,
  parameter int CNT_W = 16
) (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Enable
  input wire logic start, // Start
  input wire logic start_ready, // Idle
  input wire timing_pkg::instr_class_e iclass, // Class
  input wire logic item_mark, // Mark
  input wire logic im_trap, // Trap
  input wire logic [LEN_W-1:0] len_a, // A length
  input wire logic [LEN_W-1:0] len_b, // B length
  input wire logic [7:0] sense_sw, // Switches
  input wire logic rwc_busy, // Busy
  input wire logic ext_intr, // Interrupt pin
  input wire logic [timing_pkg::SECTOR_W-1:0] slot_sector, // Slot
  input wire logic io_strobe, // Strobe
  input wire logic [timing_pkg::SECTOR_W-1:0] io_sector, // Sector
  input wire logic [7:0] sense_val, // Tested
  input wire logic restart, // Restart
  input wire logic done, // Done
  input wire logic [CNT_W-1:0] cycles_half, // Time
  input wire logic [31:0] corr_est_ppm // Estimate
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  instr_class_e cls_r;
  logic trap_r;
  logic [LEN_W-1:0] la_r;
  logic [LEN_W-1:0] lb_r;
  logic [2:0] intr_hist_r;
  logic intr_seen_r;
  // Marks pin activity whose service time may still land in the next total
  always_ff @(posedge mclk) begin
    if (rst) begin
      intr_hist_r <= 3'h0;
      intr_seen_r <= 1'b0;
    end else if (ce) begin
      intr_hist_r <= {intr_hist_r[1:0], ext_intr};
      if (ext_intr || intr_hist_r != 3'h0) begin
        intr_seen_r <= 1'b1;
      end else if (done) begin
        intr_seen_r <= 1'b0;
      end
    end
  end
  // Holds what the accepted instruction asked for
  always_ff @(posedge mclk) begin
    if (ce && start && start_ready) begin
      cls_r <= iclass;
      trap_r <= item_mark && im_trap;
      la_r <= len_a;
      lb_r <= len_b;
    end
  end
  sequence s_take;
    ce && start && start_ready;
  endsequence
  sequence s_fin(instr_class_e c);
    done && !trap_r && !intr_seen_r && cls_r == c;
  endsequence
  chk_item_trap: assert property (done && trap_r && !intr_seen_r |-> cycles_half == ONE_CYCLE_H)
    else $error("trapped opcode time wrong");
  chk_branch_time: assert property (s_fin(CLS_BRANCH) |-> cycles_half == ONE_CYCLE_H)
    else $error("branch time wrong");
  chk_branch_sense: assert property (s_take ##0 iclass == CLS_BRANCH |=> sense_val == $past(sense_sw))
    else $error("sense switches not latched");
  chk_monitor_time: assert property (s_fin(CLS_MONITOR) |-> cycles_half == ONE_CYCLE_H)
    else $error("monitor call time wrong");
  chk_store_time: assert property (s_fin(CLS_STORE_VI) |-> cycles_half == la_r + 2)
    else $error("store variant time wrong");
  chk_restore_time: assert property (s_fin(CLS_RESTORE_VI) |-> cycles_half == la_r + 2)
    else $error("restore variant time wrong");
  chk_move_time: assert property (s_fin(CLS_MOVE_WM) |-> cycles_half == 2 * la_r + (la_r[0] ? 2 : 0))
    else $error("move time wrong");
  chk_divzero_time: assert property (s_fin(CLS_DIV_ZERO) |-> cycles_half == 2 + 4 * ((la_r + 1) / 2))
    else $error("zero divide time wrong");
  chk_corr_est: assert property (s_fin(CLS_DIV_ZERO) |-> corr_est_ppm == lb_r * CORR_PROB_PPM)
    else $error("correction estimate wrong");
  chk_slot_only: assert property (io_strobe |-> io_sector == slot_sector)
    else $error("character outside its slot");
  chk_restart_busy: assert property (restart |-> rwc_busy)
    else $error("restart without busy channel");
  chk_done_answer: assert property (s_take |-> ##[1:1000] (done || restart))
    else $error("no completion");
endmodule
bind instr_timing instr_timing_checker #(.LEN_W(LEN_W), .CNT_W(CNT_W)) u_chk (.mclk(mclk),
  .rst(rst), .ce(ce), .start(start), .start_ready(start_ready), .iclass(iclass),
  .item_mark(item_mark), .im_trap(im_trap), .len_a(len_a), .len_b(len_b), .sense_sw(sense_sw),
  .rwc_busy(rwc_busy), .ext_intr(ext_intr), .slot_sector(slot_sector), .io_strobe(io_strobe),
  .io_sector(io_sector), .sense_val(sense_val), .restart(restart), .done(done),
  .cycles_half(cycles_half), .corr_est_ppm(corr_est_ppm));
`default_nettype wire

// ### io_sector_model.sv
// Sector traffic model: rotates memory slots and accepts characters
`timescale 1ns/1ps
`default_nettype none
module io_sector_model
  import timing_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic io_strobe, // Character offered
  input wire logic [timing_pkg::SECTOR_W-1:0] io_sector, // Its sector
  output logic [timing_pkg::SECTOR_W-1:0] slot_sector, // Slot owner
  output logic [15:0] n_taken // Characters accepted
);
  // Each memory cycle belongs to the next sector; only its own slot takes a character
  always_ff @(posedge mclk) begin
    if (rst) begin
      slot_sector <= '0;
      n_taken <= 16'h0000;
    end else begin
      slot_sector <= slot_sector + 1'b1;
      if (io_strobe && io_sector == slot_sector) begin
        n_taken <= n_taken + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ### instr_timing_bench.sv
// Self-checking bench for the instruction cycle timing block
`timescale 1ns/1ps
`default_nettype none
module instr_timing_bench;
  import timing_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, start = 1'b0, item_mark = 1'b0, im_trap = 1'b0;
  logic sign_change = 1'b0, term_in_a = 1'b0, float_dollar = 1'b0, rwc_busy = 1'b0;
  logic ext_intr = 1'b0, start_ready, io_strobe, restart, done, saw_r;
  instr_class_e iclass = CLS_BRANCH;
  logic [11:0] len_a = 12'h000, len_b = 12'h000, base_cyc = 12'h000, io_chars = 12'h000;
  logic [7:0] sense_sw = 8'h00, sense_val;
  logic [1:0] sector = 2'h0, slot_sector, io_sector;
  logic [15:0] cycles_half, n_taken, c0, c1;
  logic [31:0] corr_est_ppm;
  int errors = 0, n_tests = 0, strobes = 0, irq = 0;
  instr_timing dut (.mclk(mclk), .rst(rst), .ce(ce), .start(start), .start_ready(start_ready),
    .iclass(iclass), .item_mark(item_mark), .im_trap(im_trap), .len_a(len_a), .len_b(len_b),
    .sign_change(sign_change), .term_in_a(term_in_a), .float_dollar(float_dollar),
    .sense_sw(sense_sw), .base_cyc(base_cyc), .sector(sector), .io_chars(io_chars),
    .slot_sector(slot_sector), .rwc_busy(rwc_busy), .ext_intr(ext_intr), .io_strobe(io_strobe),
    .io_sector(io_sector), .sense_val(sense_val), .restart(restart), .done(done),
    .cycles_half(cycles_half), .corr_est_ppm(corr_est_ppm));
  io_sector_model peer (.mclk(mclk), .rst(rst), .io_strobe(io_strobe), .io_sector(io_sector),
    .slot_sector(slot_sector), .n_taken(n_taken));
  always #2 mclk = ~mclk;
  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // Runs one instruction; irq gives the cycle at which an interrupt pulse begins
  task automatic op(input instr_class_e c, input logic [11:0] a, input logic [11:0] b,
    input logic [11:0] n, output logic [15:0] cy);
    int i;
    @(negedge mclk);
    iclass = c;
    len_a = a;
    len_b = b;
    base_cyc = n;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    chk("ready", 32'h0, start_ready);
    saw_r = 1'b0;
    strobes = 0;
    for (i = 0; i < 900 && done !== 1'b1 && saw_r !== 1'b1; i++) begin
      ext_intr = irq != 0 && i >= irq && i < irq + 4;
      @(negedge mclk);
      if (restart === 1'b1) saw_r = 1'b1;
      if (io_strobe === 1'b1) strobes++;
    end
    ext_intr = 1'b0;
    cy = cycles_half;
    if (i == 900) begin
      errors++;
      $display("[ERR] completion exp 1 got 0");
      conclude();
    end
  endtask
  task automatic t_short;
    sense_sw = 8'hA5;
    op(CLS_BRANCH, 12'h000, 12'h000, 12'h000, c0);
    chk("branch", 32'h2, c0);
    chk("sense", 32'hA5, sense_val);
    op(CLS_MONITOR, 12'h000, 12'h000, 12'h000, c0);
    chk("monitor", 32'h2, c0);
    op(CLS_CSM, 12'h000, 12'h000, 12'h000, c0);
    chk("csm", 32'h2, c0);
    item_mark = 1'b1;
    im_trap = 1'b1;
    op(CLS_STORE_VI, 12'h014, 12'h000, 12'h000, c0);
    chk("trapped", 32'h2, c0);
    im_trap = 1'b0;
    op(CLS_STORE_VI, 12'h014, 12'h000, 12'h000, c0);
    chk("store", 32'h16, c0);
    item_mark = 1'b0;
    op(CLS_RESTORE_VI, 12'h007, 12'h000, 12'h000, c0);
    chk("restore", 32'h9, c0);
  endtask
  task automatic t_terms;
    op(CLS_DEC_ADD, 12'h005, 12'h009, 12'h000, c0);
    sign_change = 1'b1;
    op(CLS_DEC_ADD, 12'h005, 12'h009, 12'h000, c1);
    chk("sign", 32'hC, c1 - c0);
    chk("nosign", 32'h0, c0);
    term_in_a = 1'b1;
    op(CLS_TERM, 12'h006, 12'h008, 12'h000, c0);
    term_in_a = 1'b0;
    op(CLS_TERM, 12'h006, 12'h008, 12'h000, c1);
    chk("term", 32'h4, c1 - c0);
    chk("term_a", 32'h0, c0);
    op(CLS_TABLE_LU, 12'h005, 12'h003, 12'h003, c0);
    chk("lookup", 32'h18, c0);
    op(CLS_EDIT, 12'h008, 12'h002, 12'h000, c0);
    op(CLS_EDIT, 12'h008, 12'h009, 12'h000, c1);
    chk("dollar", 32'h0, c1 - c0);
    float_dollar = 1'b1;
    op(CLS_EDIT, 12'h008, 12'h002, 12'h000, c1);
    chk("dollar_on", 32'h4, c1 - c0);
    float_dollar = 1'b0;
    op(CLS_MOVE_WM, 12'h005, 12'h000, 12'h000, c0);
    chk("move_odd", 32'hC, c0);
    op(CLS_DIV_ZERO, 12'h005, 12'h00A, 12'h000, c0);
    chk("divide", 32'hE, c0);
    chk("estimate", 32'h0000D930, corr_est_ppm);
  endtask
  task automatic t_events;
    op(CLS_LOAD_AM, 12'h050, 12'h050, 12'h000, c0);
    chk("move_even", 32'hA0, c0);
    irq = 4;
    op(CLS_LOAD_AM, 12'h050, 12'h050, 12'h000, c1);
    chk("interrupt", 32'h6, c1 - c0);
    irq = 0;
    sector = 2'h2;
    io_chars = 12'h004;
    c1 = n_taken;
    op(CLS_PERIPH, 12'h000, 12'h000, 12'h003, c0);
    chk("strobes", 32'h4, strobes);
    chk("taken", 32'h4, n_taken - c1);
    rwc_busy = 1'b1;
    io_chars = 12'h028;
    irq = 40;
    op(CLS_PERIPH, 12'h000, 12'h000, 12'h003, c0);
    chk("restart", 32'h1, saw_r);
    irq = 0;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_short();
    t_terms();
    t_events();
    conclude();
  end
endmodule
`default_nettype wire
